// ### design/adt_system.sv
`timescale 1ns/100ps
module adt_system import adt_pkg::*; #(
  parameter int SETTLE = SETTLE_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  adt_if.sys bus,
  input wire logic [CMD_W-1:0] cmd_in,
  input wire logic [3:0] res_sel,
  output logic [31:0] res_data,
  output logic ddr_ready
);
  // ----------------------------------------
  // command lines and settling
  // ----------------------------------------
  logic [CMD_W-1:0] gpio_r;
  logic [31:0] settle_r;
  logic init_r;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      gpio_r <= '0;
      settle_r <= 32'h0;
      init_r <= 1'b0;
    end else begin
      gpio_r <= cmd_in;
      if (!init_r) begin
        settle_r <= settle_r + 32'h1;
        init_r <= (settle_r == 32'(SETTLE - 1));
      end
    end
  end

  // ----------------------------------------
  // write side: accept freely, answer each burst
  // ----------------------------------------
  logic [NB_W-1:0] bpend_r;
  logic bvalid_r;
  wire logic wl_fire = bus.wvalid & init_r & bus.wlast;
  wire logic bk_fire = bvalid_r & bus.bready;
  wire logic b_load = (!bvalid_r || bk_fire) && (bpend_r != '0);
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      bpend_r <= '0;
      bvalid_r <= 1'b0;
    end else begin
      bpend_r <= bpend_r + NB_W'(wl_fire) - NB_W'(b_load);
      if (b_load) begin
        bvalid_r <= 1'b1;
      end else if (bk_fire) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // read side: four slot address queue, at most three addresses held
  // ----------------------------------------
  logic [AW-1:0] q_addr [OUTSTANDING];
  logic [1:0] q_wp_r;
  logic [1:0] q_rp_r;
  logic [2:0] q_cnt_r;
  logic arready_r;
  logic serve_r;
  logic [3:0] lat_r;
  logic [3:0] beat_r;
  logic [AW-1:0] cur_r;
  logic rvalid_r;
  logic rlast_r;
  wire logic ar_fire = bus.arvalid & arready_r;
  wire logic rd_fire = rvalid_r & bus.rready;
  wire logic take = !serve_r && (q_cnt_r != 3'h0);
  wire logic [2:0] q_nxt = q_cnt_r + {2'h0, ar_fire} - {2'h0, take};
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      q_wp_r <= 2'h0;
      q_rp_r <= 2'h0;
      q_cnt_r <= 3'h0;
      arready_r <= 1'b0;
      serve_r <= 1'b0;
      lat_r <= 4'h0;
      beat_r <= 4'h0;
      cur_r <= '0;
      rvalid_r <= 1'b0;
      rlast_r <= 1'b0;
    end else begin
      arready_r <= init_r && (q_nxt < 3'(OUTSTANDING - 1));
      q_cnt_r <= q_nxt;
      if (ar_fire) begin
        q_addr[q_wp_r] <= bus.araddr;
        q_wp_r <= q_wp_r + 2'h1;
      end
      // first beat after rcd plus cas
      if (take) begin
        cur_r <= q_addr[q_rp_r];
        q_rp_r <= q_rp_r + 2'h1;
        serve_r <= 1'b1;
        lat_r <= 4'(RD_LAT);
        beat_r <= 4'h0;
      end else if (serve_r && lat_r != 4'h0) begin
        lat_r <= lat_r - 4'h1;
      end else if (serve_r && (!rvalid_r || rd_fire)) begin
        if (rd_fire && rlast_r) begin
          serve_r <= 1'b0;
          rvalid_r <= 1'b0;
        end else begin
          rvalid_r <= 1'b1;
          rlast_r <= (beat_r == LAST_BEAT);
          beat_r <= beat_r + 4'h1;
          if (rvalid_r) begin
            cur_r <= cur_r + AW'(DW / 8);
          end
        end
      end
    end
  end

  // ----------------------------------------
  // ahb-lite result slave, one wait state
  // ----------------------------------------
  logic [31:0] store [RES_SLOTS];
  logic hready_r;
  logic dph_r;
  logic [3:0] slot_r;
  logic [31:0] res_r;
  wire logic [AW-1:0] off = bus.haddr - RES_BASE;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      hready_r <= 1'b1;
      dph_r <= 1'b0;
      slot_r <= 4'h0;
      res_r <= 32'h0;
    end else begin
      res_r <= store[res_sel];
      if (dph_r && !hready_r) begin
        hready_r <= 1'b1;
      end else if (dph_r) begin
        store[slot_r] <= bus.hwdata;
        dph_r <= 1'b0;
      end
      if (hready_r && bus.htrans == HTRANS_NONSEQ && bus.hwrite) begin
        slot_r <= off[5:2];
        dph_r <= 1'b1;
        hready_r <= 1'b0;
      end
    end
  end

  assign res_data = res_r;
  assign ddr_ready = init_r;
  assign bus.gpio_cmd = gpio_r;
  assign bus.awready = init_r;
  assign bus.wready = init_r;
  assign bus.bvalid = bvalid_r;
  assign bus.bresp = RESP_OKAY;
  assign bus.arready = arready_r;
  assign bus.rvalid = rvalid_r;
  assign bus.rlast = rlast_r;
  assign bus.rdata = {~cur_r, cur_r};
  // no ecc, so a read never reports an error
  assign bus.rresp = RESP_OKAY;
  assign bus.hready = hready_r;
  assign bus.hresp = 1'b0;
endmodule : adt_system

// ### design/adt_tester.sv
`timescale 1ns/100ps
module adt_tester import adt_pkg::*; (
  input wire logic sys_clk,
  input wire logic rstn,
  adt_if.tester bus,
  output logic busy,
  output logic [31:0] last_count
);
  // ----------------------------------------
  // command decode
  // ----------------------------------------
  wire logic [1:0] op = bus.gpio_cmd[OP_LSB +: 2];
  wire logic [NB_W-1:0] wr_bursts = adt_bursts(bus.gpio_cmd[WSZ_LSB +: 3]);
  wire logic [NB_W-1:0] rd_bursts = adt_bursts(bus.gpio_cmd[RSZ_LSB +: 3]);
  wire logic go_wr = (op == OP_WRITE) && (wr_bursts != '0);
  wire logic go_rd = (op == OP_READ) && (rd_bursts != '0);
  wire logic go = go_wr | go_rd;
  adt_state_t state_r;
  logic go_prev_r, wr_mode_r, awv_r, arv_r, wvalid_r, wlast_r, rready_r, dphase_r, busy_r;
  logic [NB_W-1:0] nburst_r, ax_left_r, b_left_r;
  logic [BEAT_W-1:0] beat_left_r, seq_r, total_r;
  logic [31:0] cnt_r, result_r, hwdata_r, last_r;
  logic [3:0] iter_r;
  logic [7:0] res_idx_r;
  logic [AW-1:0] ax_addr_r, haddr_r;
  logic [1:0] htrans_r;
  logic [DW-1:0] wdata_r;
  logic [DW-1:0] mem [MEM_DEPTH];
  wire logic run = (state_r == ST_RUN);
  wire logic ax_fire = (awv_r & bus.awready) | (arv_r & bus.arready);
  wire logic ax_free = ~(awv_r | arv_r) | ax_fire;
  wire logic w_fire = wvalid_r & bus.wready;
  wire logic r_fire = rready_r & bus.rvalid;
  wire logic b_fire = bus.bvalid;
  wire logic last_fire = (beat_left_r == BEAT_W'(1)) &&
                         ((w_fire & wlast_r) | (r_fire & bus.rlast));
  // counting opens with the first address valid, not the first run cycle
  wire logic cnt_on = (cnt_r != '0) | awv_r | arv_r;
  wire logic run_done = (beat_left_r == '0) && (!wr_mode_r || b_left_r == '0);
  // ----------------------------------------
  // result buffer, two entries
  // ----------------------------------------
  logic [63:0] buf_q [2];
  logic buf_wp_r;
  logic buf_rp_r;
  logic [1:0] buf_cnt_r;
  wire logic push_rdy = (buf_cnt_r != 2'h2);
  wire logic push = (state_r == ST_POST) && push_rdy;
  wire logic pop_vld = (buf_cnt_r != 2'h0);
  wire logic pop = (htrans_r == HTRANS_NONSEQ) && bus.hready;
  wire logic [AW-1:0] res_addr = RES_BASE + (AW'(res_idx_r) << 2);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      buf_wp_r <= 1'b0;
      buf_rp_r <= 1'b0;
      buf_cnt_r <= 2'h0;
    end else begin
      if (push) begin
        buf_q[buf_wp_r] <= {res_addr, result_r};
        buf_wp_r <= ~buf_wp_r;
      end
      if (pop) begin
        buf_rp_r <= ~buf_rp_r;
      end
      buf_cnt_r <= buf_cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      go_prev_r <= 1'b0;
      wr_mode_r <= 1'b0;
      nburst_r <= '0;
      iter_r <= 4'h0;
      res_idx_r <= 8'h00;
      cnt_r <= 32'h0;
      result_r <= 32'h0;
    end else begin
      go_prev_r <= go;
      unique case (state_r)
        // start only on a fresh command so a held word does not retrigger
        ST_IDLE: if (go && !go_prev_r) begin
          wr_mode_r <= go_wr;
          nburst_r <= go_wr ? wr_bursts : rd_bursts;
          iter_r <= 4'h0;
          res_idx_r <= 8'h00;
          state_r <= ST_PREP;
        end
        ST_PREP: begin
          cnt_r <= 32'h0;
          state_r <= ST_RUN;
        end
        ST_RUN: begin
          cnt_r <= cnt_r + {31'h0, cnt_on};
          if (last_fire) begin
            result_r <= cnt_r + 32'h1;
          end
          if (run_done) begin
            state_r <= ST_POST;
          end
        end
        ST_POST: if (push_rdy) begin
          res_idx_r <= res_idx_r + 8'h1;
          iter_r <= iter_r + 4'h1;
          state_r <= (iter_r == REPEATS - 4'h1) ? ST_IDLE : ST_PREP;
        end
      endcase
    end
  end
  // ----------------------------------------
  // address channels
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ax_left_r <= '0;
      ax_addr_r <= WR_BASE;
      awv_r <= 1'b0;
      arv_r <= 1'b0;
    end else if (state_r == ST_PREP) begin
      ax_left_r <= nburst_r;
      // base; linear walk stays in a row as long as possible
      ax_addr_r <= wr_mode_r ? WR_BASE : RD_BASE;
    end else begin
      if (ax_fire) begin
        ax_addr_r <= ax_addr_r + BURST_STEP;
      end
      // issue back to back, no wait for responses
      if (run && ax_free && ax_left_r != '0) begin
        awv_r <= wr_mode_r;
        arv_r <= ~wr_mode_r;
        ax_left_r <= ax_left_r - NB_W'(1);
      end else if (ax_fire) begin
        awv_r <= 1'b0;
        arv_r <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // data channels and local ram
  // ----------------------------------------
  wire logic w_more = run && wr_mode_r && (seq_r != total_r);
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      seq_r <= '0;
      total_r <= '0;
      beat_left_r <= '0;
      b_left_r <= '0;
      wvalid_r <= 1'b0;
      wlast_r <= 1'b0;
      wdata_r <= '0;
      rready_r <= 1'b0;
    end else if (state_r == ST_PREP) begin
      seq_r <= '0;
      total_r <= {nburst_r, 4'h0};
      beat_left_r <= {nburst_r, 4'h0};
      b_left_r <= nburst_r;
      rready_r <= ~wr_mode_r;
    end else begin
      if (w_more && (!wvalid_r || w_fire)) begin
        wdata_r <= mem[seq_r[MEM_AW-1:0]];
        wlast_r <= (seq_r[3:0] == LAST_BEAT);
        wvalid_r <= 1'b1;
        seq_r <= seq_r + BEAT_W'(1);
      end else if (w_fire) begin
        wvalid_r <= 1'b0;
      end
      if (r_fire) begin
        mem[seq_r[MEM_AW-1:0]] <= bus.rdata;
        seq_r <= seq_r + BEAT_W'(1);
      end
      if (w_fire || r_fire) begin
        beat_left_r <= beat_left_r - BEAT_W'(1);
      end
      if (b_fire && b_left_r != '0) begin
        b_left_r <= b_left_r - NB_W'(1);
      end
      if (state_r == ST_POST) begin
        rready_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // ahb-lite result writer
  // ----------------------------------------
  wire logic [63:0] head = buf_q[buf_rp_r];
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      haddr_r <= RES_BASE;
      htrans_r <= HTRANS_IDLE;
      hwdata_r <= 32'h0;
      dphase_r <= 1'b0;
      busy_r <= 1'b0;
      last_r <= 32'h0;
    end else begin
      busy_r <= (state_r != ST_IDLE) || pop_vld || dphase_r || (htrans_r != HTRANS_IDLE);
      if (push) begin
        last_r <= result_r;
      end
      if (pop) begin
        htrans_r <= HTRANS_IDLE;
        hwdata_r <= head[31:0];
        dphase_r <= 1'b1;
      end else if (dphase_r && bus.hready) begin
        dphase_r <= 1'b0;
      end else if (!dphase_r && htrans_r == HTRANS_IDLE && pop_vld) begin
        haddr_r <= head[63:32];
        htrans_r <= HTRANS_NONSEQ;
      end
    end
  end
  assign busy = busy_r;
  assign last_count = last_r;
  assign bus.awaddr = ax_addr_r;
  assign bus.araddr = ax_addr_r;
  assign bus.awvalid = awv_r;
  assign bus.arvalid = arv_r;
  assign bus.awlen = AX_LEN;
  assign bus.arlen = AX_LEN;
  assign bus.awsize = AX_SIZE;
  assign bus.arsize = AX_SIZE;
  assign bus.awburst = AX_INCR;
  assign bus.arburst = AX_INCR;
  assign bus.wdata = wdata_r;
  assign bus.wstrb = WSTRB_ALL;
  assign bus.wlast = wlast_r;
  assign bus.wvalid = wvalid_r;
  assign bus.bready = 1'b1;
  assign bus.rready = rready_r;
  assign bus.haddr = haddr_r;
  assign bus.htrans = htrans_r;
  assign bus.hwrite = 1'b1;
  assign bus.hsize = HSIZE_WORD;
  assign bus.hwdata = hwdata_r;
endmodule : adt_tester

// ### dv/adt_props.sv
`timescale 1ns/100ps
module adt_props import adt_pkg::*; (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [CMD_W-1:0] gpio_cmd,
  input wire logic [AW-1:0] awaddr,
  input wire logic [7:0] awlen,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [7:0] wstrb,
  input wire logic wlast,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [AW-1:0] araddr,
  input wire logic [7:0] arlen,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rlast,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [AW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ----------------
  // beat tracking
  // ----------------
  logic [3:0] wbeat_r;
  logic [3:0] rbeat_r;
  wire wr_go;
  wire rd_go;
  assign wr_go = gpio_cmd[1:0] == OP_WRITE && gpio_cmd[4:2] inside {[SZ_2K:SZ_32K]};
  assign rd_go = gpio_cmd[1:0] == OP_READ && gpio_cmd[7:5] inside {[SZ_2K:SZ_32K]};
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wbeat_r <= 4'h0;
      rbeat_r <= 4'h0;
    end else begin
      if (wvalid && wready) wbeat_r <= wbeat_r + 4'h1;
      if (rvalid && rready) rbeat_r <= rbeat_r + 4'h1;
    end
  end
  // ----------------
  // properties
  // ----------------
  a_write_start: assert property (
    $rose(wr_go) |-> ##[2:3] (awvalid && !arvalid)) else $error("write not started");
  a_read_start: assert property (
    $rose(rd_go) |-> ##[2:3] (arvalid && !awvalid)) else $error("read not started");
  a_aw_window: assert property (
    awvalid |-> awlen == AX_LEN && awaddr[6:0] == 7'h00 && awaddr < WR_BASE + 32'h0000_8000)
    else $error("write address off grid");
  a_ar_window: assert property (
    arvalid |-> arlen == AX_LEN && araddr[6:0] == 7'h00 && araddr >= RD_BASE
      && araddr < RD_BASE + 32'h0000_8000) else $error("read address off grid");
  a_aw_hold: assert property (
    awvalid && !awready |=> awvalid && $stable(awaddr)) else $error("write address dropped");
  a_ar_hold: assert property (
    arvalid && !arready |=> arvalid && $stable(araddr)) else $error("read address dropped");
  a_wlast_beat: assert property (
    wvalid |-> wlast == (wbeat_r == LAST_BEAT) && wstrb == WSTRB_ALL) else $error("wlast misplaced");
  a_rlast_beat: assert property (
    rvalid && rready |-> rlast == (rbeat_r == LAST_BEAT)) else $error("rlast misplaced");
  a_read_accept: assert property (
    rvalid |-> rready) else $error("read beat not accepted");
  a_ahb_word: assert property (
    htrans == HTRANS_NONSEQ |-> hwrite && hsize == HSIZE_WORD && haddr[1:0] == 2'h0
      && haddr >= RES_BASE && haddr < RES_BASE + 32'h0000_0020) else $error("bad result write");
  a_ahb_wait: assert property (
    htrans == HTRANS_NONSEQ |=> (htrans == HTRANS_IDLE && !hready) ##1 hready)
    else $error("result write phase wrong");
  c_write: cover property ($rose(wr_go));
  c_read: cover property ($rose(rd_go));
  c_ar_stall: cover property (arvalid && !arready);
  c_result: cover property (htrans == HTRANS_NONSEQ);
endmodule : adt_props

// ### dv/axi_ddr_throughput_tester_tb.sv
`timescale 1ns/100ps
module axi_ddr_throughput_tester_tb import adt_pkg::*; ;
  logic sys_clk;
  logic rstn;
  logic [CMD_W-1:0] cmd_in;
  logic [3:0] res_sel;
  logic [31:0] res_data;
  logic ddr_ready;
  logic busy;
  logic [31:0] last_count;
  logic on;
  logic rd_mode;
  logic [AW-1:0] a;
  int mismatches;
  int n_compared;
  int cyc;
  int bursts;
  int beats;
  int naddr;
  int nb;
  int cnts[$];
  adt_if ifc();
  adt_tester u_adt_tester (.sys_clk(sys_clk), .rstn(rstn), .bus(ifc.tester), .busy(busy),
    .last_count(last_count));
  adt_system #(.SETTLE(20)) u_adt_system (.sys_clk(sys_clk), .rstn(rstn), .bus(ifc.sys),
    .cmd_in(cmd_in), .res_sel(res_sel), .res_data(res_data), .ddr_ready(ddr_ready));
  adt_props u_adt_props (.sys_clk(sys_clk), .rstn(rstn), .gpio_cmd(ifc.gpio_cmd),
    .awaddr(ifc.awaddr), .awlen(ifc.awlen), .awvalid(ifc.awvalid), .awready(ifc.awready),
    .wstrb(ifc.wstrb), .wlast(ifc.wlast), .wvalid(ifc.wvalid), .wready(ifc.wready),
    .araddr(ifc.araddr), .arlen(ifc.arlen), .arvalid(ifc.arvalid), .arready(ifc.arready),
    .rlast(ifc.rlast), .rvalid(ifc.rvalid), .rready(ifc.rready), .haddr(ifc.haddr),
    .htrans(ifc.htrans), .hwrite(ifc.hwrite), .hsize(ifc.hsize), .hready(ifc.hready));
  // ----------------
  // helpers
  // ----------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  // cycle count runs from the first address valid to the closing last handshake
  always @(posedge sys_clk) begin
    if (!on && (rd_mode ? ifc.arvalid : ifc.awvalid)) on = 1'b1;
    if (on) cyc++;
    if (rd_mode ? ifc.arvalid && ifc.arready : ifc.awvalid && ifc.awready) naddr++;
    if (rd_mode ? ifc.rvalid && ifc.rready : ifc.wvalid && ifc.wready) begin
      a = RD_BASE + 32'(8 * (beats % MEM_DEPTH));
      if (!rd_mode) check(ifc.wdata, {~a, a}, "wdata");
      beats++;
      if (rd_mode ? ifc.rlast : ifc.wlast) bursts++;
      if (bursts == nb) begin
        cnts.push_back(cyc);
        on = 1'b0;
        cyc = 0;
        bursts = 0;
        beats = 0;
      end
    end
  end
  // ----------------
  // scenarios
  // ----------------
  task automatic nop_cmds();
    logic [7:0] words [6] = '{8'h24, 8'hff, 8'h01, 8'h1d, 8'h02, 8'hc2};
    for (int i = 0; i < 6; i++) begin
      @(negedge sys_clk) cmd_in = words[i];
      repeat (6) @(negedge sys_clk);
      check(busy, 1'b0, "nop busy");
      check(ifc.awvalid | ifc.arvalid, 1'b0, "nop traffic");
    end
    @(negedge sys_clk) cmd_in = 8'h00;
  endtask : nop_cmds
  task automatic run_cmd(input logic [7:0] cmd, input logic rd, input int n);
    int k;
    rd_mode = rd;
    nb = n;
    naddr = 0;
    cnts.delete();
    @(negedge sys_clk) cmd_in = cmd;
    repeat (3) @(negedge sys_clk);
    check(busy, 1'b1, "busy");
    k = 0;
    while (busy !== 1'b0 && k < 60000) begin
      @(negedge sys_clk);
      k++;
    end
    repeat (10) @(negedge sys_clk);
    check(busy, 1'b0, "retrigger");
    check(naddr, 8 * n, "bursts");
    check(cnts.size(), 8, "passes");
    for (int i = 0; i < 8; i++) begin
      res_sel = 4'(i);
      repeat (2) @(negedge sys_clk);
      check(res_data, cnts[i], "count");
    end
    check(last_count, cnts[7], "last count");
    cmd_in = 8'h00;
  endtask : run_cmd
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (90000) @(posedge sys_clk);
    mismatches++;
    $display("wrong value at %0t: watchdog expired", $time);
    give_verdict();
  end
  initial begin
    cmd_in = 8'h00;
    res_sel = 4'h0;
    rstn = 1'b0;
    on = 1'b0;
    rd_mode = 1'b0;
    repeat (10) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (15) @(negedge sys_clk);
    check(ddr_ready, 1'b0, "early ready");
    repeat (10) @(negedge sys_clk);
    check(ddr_ready, 1'b1, "ready");
    nop_cmds();
    // a 4K read fills the whole local ram so later writes show known data
    run_cmd(8'h42, 1'b1, 32);
    for (int s = 1; s < 6; s++) begin
      run_cmd({3'h0, 3'(s), OP_WRITE}, 1'b0, 16 << (s - 1));
    end
    give_verdict();
  end
endmodule : axi_ddr_throughput_tester_tb

// ### inc/adt_if.sv
`timescale 1ns/100ps
interface adt_if;
  import adt_pkg::*;
  logic [CMD_W-1:0] gpio_cmd;
  logic [AW-1:0] awaddr;
  logic [7:0] awlen;
  logic [2:0] awsize;
  logic [1:0] awburst;
  logic awvalid;
  logic awready;
  logic [DW-1:0] wdata;
  logic [7:0] wstrb;
  logic wlast;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [AW-1:0] araddr;
  logic [7:0] arlen;
  logic [2:0] arsize;
  logic [1:0] arburst;
  logic arvalid;
  logic arready;
  logic [DW-1:0] rdata;
  logic [1:0] rresp;
  logic rlast;
  logic rvalid;
  logic rready;
  logic [AW-1:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hready;
  logic hresp;

  modport tester (
    input gpio_cmd,
    output awaddr, awlen, awsize, awburst, awvalid, input awready,
    output wdata, wstrb, wlast, wvalid, input wready,
    input bresp, bvalid, output bready,
    output araddr, arlen, arsize, arburst, arvalid, input arready,
    input rdata, rresp, rlast, rvalid, output rready,
    output haddr, htrans, hwrite, hsize, hwdata, input hready, hresp
  );
  modport sys (
    output gpio_cmd,
    input awaddr, awlen, awsize, awburst, awvalid, output awready,
    input wdata, wstrb, wlast, wvalid, output wready,
    output bresp, bvalid, input bready,
    input araddr, arlen, arsize, arburst, arvalid, output arready,
    output rdata, rresp, rlast, rvalid, input rready,
    input haddr, htrans, hwrite, hsize, hwdata, output hready, hresp
  );
endinterface : adt_if

// ### inc/adt_pkg.sv
package adt_pkg;
  // ----------------------------------------
  // command word layout and codes
  // ----------------------------------------
  localparam int CMD_W = 8;
  localparam int OP_LSB = 0;
  localparam int WSZ_LSB = 2;
  localparam int RSZ_LSB = 5;
  localparam logic [1:0] OP_NOP0 = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_NOP3 = 2'h3;
  localparam logic [2:0] SZ_NONE = 3'h0;
  localparam logic [2:0] SZ_2K = 3'h1;
  localparam logic [2:0] SZ_4K = 3'h2;
  localparam logic [2:0] SZ_8K = 3'h3;
  localparam logic [2:0] SZ_16K = 3'h4;
  localparam logic [2:0] SZ_32K = 3'h5;
  // ----------------------------------------
  // bus geometry
  // ----------------------------------------
  localparam int AW = 32;
  localparam int DW = 64;
  localparam int MEM_DEPTH = 512;
  localparam int MEM_AW = 9;
  localparam int NB_W = 9;
  localparam int BEAT_W = 13;
  localparam logic [7:0] AX_LEN = 8'h0f;
  localparam logic [2:0] AX_SIZE = 3'h3;
  localparam logic [1:0] AX_INCR = 2'h1;
  localparam logic [3:0] LAST_BEAT = 4'hf;
  localparam logic [7:0] WSTRB_ALL = 8'hff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [AW-1:0] BURST_STEP = 32'h0000_0080;
  localparam logic [AW-1:0] WR_BASE = 32'h0000_0000;
  localparam logic [AW-1:0] RD_BASE = 32'h0010_0000;
  localparam logic [AW-1:0] BANK_SPAN = 32'h0000_0800;
  localparam logic [AW-1:0] ROW_SPAN = 32'h0000_4000;
  localparam logic [3:0] REPEATS = 4'h8;
  localparam int OUTSTANDING = 4;
  // ----------------------------------------
  // result path
  // ----------------------------------------
  localparam logic [AW-1:0] RES_BASE = 32'h2000_8104;
  localparam logic [AW-1:0] RES_STEP = 32'h0000_0004;
  localparam int RES_SLOTS = 16;
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // ----------------------------------------
  // clocks and ddr timing, ddr cycles
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam real FABRIC_MHZ = 166.6;
  localparam real DDR_MHZ = 333.2;
  localparam int CLK_RATIO = 2;
  localparam int T_CAS = 5;
  localparam int T_RAS_MIN = 12;
  localparam int T_RAS_MAX = 22528;
  localparam int T_RCD = 5;
  localparam int T_RP = 5;
  localparam int T_REFI = 2592;
  localparam int T_RC = 17;
  localparam int T_RFC = 54;
  localparam int T_WR = 5;
  localparam int T_FAW = 10;
  localparam int RD_LAT = (T_RCD + T_CAS + CLK_RATIO - 1) / CLK_RATIO;
  localparam int SETTLE_US = 200;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;

  typedef enum logic [2:0] {ST_IDLE, ST_PREP, ST_RUN, ST_POST} adt_state_t;

  function automatic logic [NB_W-1:0] adt_bursts(input logic [2:0] sz);
    unique case (sz)
      SZ_2K: adt_bursts = 9'h010;
      SZ_4K: adt_bursts = 9'h020;
      SZ_8K: adt_bursts = 9'h040;
      SZ_16K: adt_bursts = 9'h080;
      SZ_32K: adt_bursts = 9'h100;
      default: adt_bursts = 9'h000;
    endcase
  endfunction : adt_bursts
endpackage : adt_pkg
